// >>> int_vector_ext_edge_timer_irq_tb.sv
// Self-checking bench of the interrupt vector block.
// Assumes the core model in ivet_core_model.sv answers the vector.
`timescale 1ns/1ps
module int_vector_ext_edge_timer_irq_tb;
  logic pclk, presetn, ce, psel, penable, pwrite;
  logic [ivet_pkg::PADDR_W-1:0] paddr; // Byte address of the access.
  logic [31:0] pwdata, prdata, rd, exp_take;
  logic pready, pslverr, er, ext_int_line0, ext_int_line1;
  logic [1:0] wake_hit; // Wake-up pulses, one per line.
  logic timer0_ovf, timer1_ovf, save_req, restore_req, reti_done;
  logic ctx_valid;
  ivet_pkg::ivet_ctx_type ctx_in, ctx_out;
  ivet_pkg::ivet_vec_type vec_out;
  logic [7:0] svc_len, n_take, n_push; // Model controls and counters.
  logic [ivet_pkg::PC_W-1:0] last_addr;
  int n_mismatch, compares;
  ivet_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_int_line0(ext_int_line0), .ext_int_line1(ext_int_line1),
    .wake_hit(wake_hit), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
    .save_req(save_req), .restore_req(restore_req), .reti_done(reti_done),
    .ctx_in(ctx_in), .ctx_out(ctx_out), .ctx_valid(ctx_valid),
    .vec_out(vec_out));
  ivet_core_model u_core (.pclk(pclk), .presetn(presetn), .vec_out(vec_out),
    .svc_len(svc_len), .reti_done(reti_done), .n_take(n_take),
    .n_push(n_push), .last_addr(last_addr));
  // The clock toggles every half period of 12.5 ns.
  always #12.5 pclk = ~pclk;
  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One-cycle event: 0/1 timer overflow, 2/3 wake-up; 4 drives pin 0 low and leaves it low.
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: timer0_ovf <= 1'b1;
      1: timer1_ovf <= 1'b1;
      2: wake_hit <= 2'b01;
      3: wake_hit <= 2'b10;
      default: ext_int_line0 <= 1'b0;
    endcase
    @(posedge pclk);
    timer0_ovf <= 1'b0;
    timer1_ovf <= 1'b0;
    wake_hit <= 2'b00;
  endtask
  // An enabled source enters the vector once; software then clears it.
  task automatic vec_case(input int which, input logic [31:0] mask);
    apb(1'b1, ivet_pkg::IDX_EN, mask);
    pulse(which);
    idle(10);
    exp_take = exp_take + 32'h0000_0001;
    chk(32'(n_take), exp_take);
    chk(32'(last_addr), 32'h0000_0008);
    chk(32'(n_push), exp_take);
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, mask);
    apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
    apb(1'b1, ivet_pkg::IDX_EN, 32'h0000_0000);
    idle(40);
    $display("vec_case done");
  endtask
  // Reset values and an unmapped index.
  task automatic t_regs;
    apb(1'b0, ivet_pkg::IDX_EDGE, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, ivet_pkg::IDX_STK, 32'h0000_0000);
    chk(32'(rd[7]), 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0000_00FF);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    $display("t_regs done");
  endtask
  // Timer flags set while disabled never vector, not even when enabled.
  task automatic t_timer_off;
    apb(1'b1, ivet_pkg::IDX_STK, 32'h0000_0080);
    pulse(0);
    pulse(1);
    idle(6);
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0030);
    apb(1'b1, ivet_pkg::IDX_EN, 32'h0000_0030);
    idle(6);
    chk(32'(n_take), exp_take);
    apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
    apb(1'b1, ivet_pkg::IDX_EN, 32'h0000_0000);
    $display("t_timer_off done");
  endtask
  // With the global enable off nothing vectors.
  task automatic t_gie;
    apb(1'b1, ivet_pkg::IDX_STK, 32'h0000_0000);
    apb(1'b1, ivet_pkg::IDX_EN, 32'h0000_0033);
    pulse(0);
    pulse(1);
    idle(6);
    chk(32'(n_take), exp_take);
    apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
    apb(1'b1, ivet_pkg::IDX_EN, 32'h0000_0000);
    apb(1'b1, ivet_pkg::IDX_STK, 32'h0000_0080);
    $display("t_gie done");
  endtask
  // Every edge code on both lines, line 0 given the opposite code.
  task automatic t_edges;
    int c;
    for (c = 0; c < 4; c++) begin
      apb(1'b1, ivet_pkg::IDX_EDGE, {28'h000_0000, c[1:0], ~c[1:0]});
      ext_int_line0 <= 1'b0;
      ext_int_line1 <= 1'b0;
      idle(8);
      apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
      chk(rd, {30'h0000_0000, c[1], ~c[1]});
      apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
      ext_int_line0 <= 1'b1;
      ext_int_line1 <= 1'b1;
      idle(8);
      apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
      chk(rd, {30'h0000_0000, c[0], ~c[0]});
      apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
    end
    apb(1'b1, ivet_pkg::IDX_EDGE, 32'h0000_000A);
    $display("t_edges done");
  endtask
  // Wake-up pulses latch a flag only where the edge code matches.
  task automatic t_wake;
    apb(1'b1, ivet_pkg::IDX_EDGE, 32'h0000_000E);
    vec_case(3, 32'h0000_0002);
    apb(1'b1, ivet_pkg::IDX_EDGE, 32'h0000_0005);
    pulse(2);
    pulse(3);
    idle(4);
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, ivet_pkg::IDX_EDGE, 32'h0000_000A);
    $display("t_wake done");
  endtask
  // A set event at the edge of a clearing write wins; a plain write clears.
  task automatic t_race;
    pulse(0);
    fork
      apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
      begin
        @(posedge pclk);
        pulse(0);
      end
    join
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    apb(1'b1, ivet_pkg::IDX_REQ, 32'h0000_0000);
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("t_race done");
  endtask
  // Two saves in a row, then a restore with live status bits.
  task automatic t_ctx;
    @(posedge pclk);
    ctx_in <= {8'h5A, 8'hFF};
    save_req <= 1'b1;
    @(posedge pclk);
    ctx_in <= {8'h3C, 8'h52};
    @(posedge pclk);
    save_req <= 1'b0;
    ctx_in <= {8'h99, 8'h0C};
    restore_req <= 1'b1;
    @(posedge pclk);
    restore_req <= 1'b0;
    @(posedge pclk);
    chk(32'(ctx_valid), 32'h0000_0001);
    chk(32'(ctx_out), 32'h0000_3C5E);
    @(posedge pclk);
    chk(32'(ctx_valid), 32'h0000_0000);
    $display("t_ctx done");
  endtask
  // A low clock enable freezes the block, so an overflow then is missed.
  task automatic t_ce;
    @(posedge pclk);
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    apb(1'b0, ivet_pkg::IDX_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("t_ce done");
  endtask
  // Print the counts and the verdict, then stop.
  task automatic wrap_up;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence; ce stays high except in t_ce, which freezes the block for one overflow.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    ext_int_line0 = 1'b1;
    ext_int_line1 = 1'b1;
    wake_hit = 2'b00;
    timer0_ovf = 1'b0;
    timer1_ovf = 1'b0;
    save_req = 1'b0;
    restore_req = 1'b0;
    ctx_in = '0;
    svc_len = 8'd30;
    exp_take = 32'h0000_0000;
    n_mismatch = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_timer_off;
    vec_case(0, 32'h0000_0010);
    vec_case(1, 32'h0000_0020);
    t_gie;
    t_edges;
    vec_case(4, 32'h0000_0001);
    ext_int_line0 <= 1'b1;
    idle(8);
    t_wake;
    t_race;
    t_ctx;
    t_ce;
    wrap_up;
  end
  // Watchdog: the sequence needs far fewer cycles than this.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
endmodule // int_vector_ext_edge_timer_irq_tb

// >>> ivet_core_model.sv
// Core-side partner: takes vectors, tracks the stack, returns later.
// Assumes vec_out pulses take and push for one pclk cycle.
`timescale 1ns/1ps
module ivet_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire ivet_pkg::ivet_vec_type vec_out,
  input wire logic [7:0] svc_len,
  output logic reti_done,
  output logic [7:0] n_take,
  output logic [7:0] n_push,
  output logic [ivet_pkg::PC_W-1:0] last_addr
);
  logic [7:0] cnt_r; // Cycles left in the service routine.
  logic busy_r; // High while the service routine runs.
  // A long service time lets software clear the flag before the return,
  // otherwise a still-set flag would be entered again at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_take <= 8'h00;
      n_push <= 8'h00;
      last_addr <= '0;
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      reti_done <= 1'b0;
    end else begin
      reti_done <= 1'b0;
      if (vec_out.take) begin
        // Record the jump target and the stack growth of this entry.
        n_take <= n_take + 8'h01;
        n_push <= n_push + 8'(vec_out.push);
        last_addr <= vec_out.addr;
        busy_r <= 1'b1;
        cnt_r <= svc_len;
      end else if (busy_r && cnt_r == 8'h00) begin
        // The routine ends and returns, popping the stack again.
        busy_r <= 1'b0;
        reti_done <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule // ivet_core_model

// >>> ivet_edge_det.sv
// Pin synchroniser and edge-select decoder for one external line.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/1ps
module ivet_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pin,
  input wire logic [1:0] sel,
  output logic trig
);
  logic s1_r; // First stage, read only by the second.
  logic s2_r; // Second stage.
  logic s3_r; // Third stage.
  logic lvl_r; // Accepted pin level.
  logic agree; // Second and third stages match.
  logic rise; // Accepted rising change.
  logic fall; // Accepted falling change.
  logic [3:0] fill_r; // Marks stages that already hold a real pin sample.
  logic armed; // The accepted level has been loaded from the pin.

  // Three-stage synchroniser, frozen while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // The stages reset low whatever the idle level of the pin is, so a
  // high idle pin would look like a rising edge just after reset.
  // Edges are ignored until real samples have reached the level flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_r <= 4'h0;
    end else if (ce) begin
      fill_r <= {fill_r[2:0], 1'b1};
    end
  end

  assign armed = fill_r[3];
  assign agree = (s2_r == s3_r);
  assign rise = armed & agree & s3_r & ~lvl_r;
  assign fall = armed & agree & ~s3_r & lvl_r;

  // A change counts only once the last two stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= 1'b0;
    end else if (ce && agree) begin
      lvl_r <= s3_r;
    end
  end

  // The reserved code never triggers.
  always_comb begin
    unique case (sel)
      ivet_pkg::EDGE_RISE: trig = rise;
      ivet_pkg::EDGE_FALL: trig = fall;
      ivet_pkg::EDGE_BOTH: trig = rise | fall;
      default: trig = 1'b0;
    endcase
  end
endmodule // ivet_edge_det

// >>> ivet_pkg.sv
// Constants and carrier types of the interrupt vector block.
// Assumes one clock domain and register access over APB.
package ivet_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_EDGE = 8'hBF;
  localparam logic [7:0] IDX_REQ = 8'hC8;
  localparam logic [7:0] IDX_EN = 8'hC9;
  localparam logic [7:0] IDX_STK = 8'hDF;
  localparam int PADDR_W = 10;
  // Reset values.
  localparam logic [3:0] EDGE_RST = 4'hA;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] REQ_RST = 8'h00;
  localparam logic GIE_RST = 1'b0;
  // Field positions in the enable and request registers, the STK register (B_GIE) and the edge register.
  localparam int B_EXT0 = 0;
  localparam int B_EXT1 = 1;
  localparam int B_T0 = 4;
  localparam int B_T1 = 5;
  localparam int B_GIE = 7;
  localparam int EDGE0_LSB = 0;
  localparam int EDGE1_LSB = 2;
  // Edge select codes.
  localparam logic [1:0] EDGE_RSVD = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Direction in which the pin wake-up logic triggers.
  localparam logic [1:0] WAKE_EDGE = 2'h2;
  // Fixed interrupt vector address.
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VEC_ADDR = 12'h008;
  // Status word bits left out of save and restore.
  localparam int PSW_TO_BIT = 2;
  localparam int PSW_PD_BIT = 3;
  localparam logic [7:0] PSW_SKIP = 8'h0C;
  // The slave answers with no wait state beyond the access cycle.
  localparam int APB_WAIT = 0;
  // Request to the core fetch and stack logic.
  typedef struct packed {
    logic take;
    logic push;
    logic [PC_W-1:0] addr;
  } ivet_vec_type;
  // Work register and status word as one pair.
  typedef struct packed {
    logic [7:0] work;
    logic [7:0] psw;
  } ivet_ctx_type;
  // Controller states.
  typedef enum logic [1:0] {
    IVET_IDLE = 2'b00,
    IVET_TAKE = 2'b01,
    IVET_SERV = 2'b10
  } ivet_state_type;
endpackage

// >>> ivet_req_flag.sv
// One sticky request flag with its qualification bit.
// Assumes set events are one-cycle pulses on pclk.
`timescale 1ns/1ps
module ivet_req_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic set_evt,
  input wire logic en,
  input wire logic wr,
  input wire logic wr_val,
  output logic flag_r,
  output logic qual_r
);
  logic flag_nxt; // Next flag value.

  // A set event outranks a software write in the same cycle.
  always_comb begin
    if (set_evt) begin
      flag_nxt = 1'b1;
    end else if (wr) begin
      flag_nxt = wr_val;
    end else begin
      flag_nxt = flag_r;
    end
  end

  // The flag is held until software writes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end

  // Only a request raised while enabled may vector; one raised while
  // disabled stays unqualified until a new set event arrives while enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_r <= 1'b0;
    end else if (ce) begin
      if (!flag_nxt) begin
        qual_r <= 1'b0;
      end else if (set_evt && en) begin
        qual_r <= 1'b1;
      end
    end
  end
endmodule // ivet_req_flag

// >>> ivet_top.sv
// Interrupt controller: pin and timer requests, one vector, context save.
// Assumes the core pulses save, restore and return on pclk, and the
// timers pulse their overflow outputs on pclk.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ivet_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ivet_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_int_line0,
  input wire logic ext_int_line1,
  input wire logic [1:0] wake_hit,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic save_req,
  input wire logic restore_req,
  input wire logic reti_done,
  input wire ivet_pkg::ivet_ctx_type ctx_in,
  output ivet_pkg::ivet_ctx_type ctx_out,
  output logic ctx_valid,
  output ivet_pkg::ivet_vec_type vec_out
);
  logic [3:0] edge_r; // Both edge select fields.
  logic [7:0] en_r; // Enable bits of the four sources.
  logic global_int_enable_r; // Global gate.
  logic [31:0] prdata_r; // Read data register.
  logic pready_r; // Access-phase ready.
  logic pslverr_r; // Unmapped access.
  ivet_pkg::ivet_state_type state_r; // Controller state.
  ivet_pkg::ivet_state_type state_nxt; // Its next value.
  ivet_pkg::ivet_vec_type vec_r; // Request to the core.
  ivet_pkg::ivet_ctx_type shadow_r; // Single-level save buffer.
  ivet_pkg::ivet_ctx_type ctx_r; // Restored context.
  logic ctx_valid_r; // Restore strobe.
  logic [1:0] ext_trig; // Pin edges after decoding.
  logic [1:0] wake_ok; // Edge select matches wake direction.
  logic [3:0] set_evt; // Source set events.
  logic [3:0] src_en; // Source enables in source order.
  logic [3:0] flag; // Request flags in source order.
  logic [3:0] qual; // Qualified requests.
  logic [3:0] req_wval; // Write values for the flags.
  logic setup; // APB setup cycle.
  logic wr_acc; // APB write taking effect.
  logic [7:0] idx; // Word index of the access.
  logic hit; // Index is mapped.
  logic [7:0] req_view; // Request register as read.
  logic pend; // A qualified, enabled request waits.

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite;
  assign idx = paddr[ivet_pkg::PADDR_W-1:2];
  assign hit = (idx == ivet_pkg::IDX_EDGE) || (idx == ivet_pkg::IDX_REQ) ||
               (idx == ivet_pkg::IDX_EN) || (idx == ivet_pkg::IDX_STK);

  // Pin lines, each with its own edge-select field.
  ivet_edge_det u_edge0 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin(ext_int_line0),
    .sel(edge_r[ivet_pkg::EDGE0_LSB +: 2]),
    .trig(ext_trig[0])
  );

  ivet_edge_det u_edge1 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin(ext_int_line1),
    .sel(edge_r[ivet_pkg::EDGE1_LSB +: 2]),
    .trig(ext_trig[1])
  );

  // A wake-up latches the request only when the directions agree.
  assign wake_ok[0] = (edge_r[1:0] == ivet_pkg::WAKE_EDGE) ||
                      (edge_r[1:0] == ivet_pkg::EDGE_BOTH);
  assign wake_ok[1] = (edge_r[3:2] == ivet_pkg::WAKE_EDGE) ||
                      (edge_r[3:2] == ivet_pkg::EDGE_BOTH);

  // Source order: line 0, line 1, timer 0, timer 1.
  assign set_evt[0] = ext_trig[0] | (wake_hit[0] & wake_ok[0]);
  assign set_evt[1] = ext_trig[1] | (wake_hit[1] & wake_ok[1]);
  assign set_evt[2] = timer0_ovf;
  assign set_evt[3] = timer1_ovf;
  assign src_en = {en_r[ivet_pkg::B_T1], en_r[ivet_pkg::B_T0],
                   en_r[ivet_pkg::B_EXT1], en_r[ivet_pkg::B_EXT0]};
  assign req_wval = {pwdata[ivet_pkg::B_T1], pwdata[ivet_pkg::B_T0],
                     pwdata[ivet_pkg::B_EXT1], pwdata[ivet_pkg::B_EXT0]};

  // Sticky flags; only a software write clears them.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      ivet_req_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set_evt(set_evt[gi]),
        .en(src_en[gi]),
        .wr(wr_acc && idx == ivet_pkg::IDX_REQ),
        .wr_val(req_wval[gi]),
        .flag_r(flag[gi]),
        .qual_r(qual[gi])
      );
    end
  endgenerate

  // Flags read back in their register positions.
  always_comb begin
    req_view = 8'h00;
    req_view[ivet_pkg::B_EXT0] = flag[0];
    req_view[ivet_pkg::B_EXT1] = flag[1];
    req_view[ivet_pkg::B_T0] = flag[2];
    req_view[ivet_pkg::B_T1] = flag[3];
  end

  // Enabled sources only, and only when raised while enabled.
  assign pend = |(qual & src_en);

  // Control registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_r <= ivet_pkg::EDGE_RST;
      en_r <= ivet_pkg::EN_RST;
      global_int_enable_r <= ivet_pkg::GIE_RST;
    end else if (ce && wr_acc) begin
      if (idx == ivet_pkg::IDX_EDGE) begin
        edge_r <= pwdata[3:0];
      end
      if (idx == ivet_pkg::IDX_EN) begin
        en_r <= pwdata[7:0];
      end
      if (idx == ivet_pkg::IDX_STK) begin
        global_int_enable_r <= pwdata[ivet_pkg::B_GIE];
      end
    end
  end

  // APB answer: read data latched in setup, ready in the access cycle.
  // Registering the data costs nothing since the access cycle exists.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        unique case (idx)
          ivet_pkg::IDX_EDGE: prdata_r <= {28'h000_0000, edge_r};
          ivet_pkg::IDX_REQ: prdata_r <= {24'h00_0000, req_view};
          ivet_pkg::IDX_EN: prdata_r <= {24'h00_0000, en_r};
          ivet_pkg::IDX_STK: prdata_r <= {24'h00_0000,
                                          global_int_enable_r, 7'h00};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Vectoring sequence: one take cycle, then service until return.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ivet_pkg::IVET_IDLE: begin
        if (global_int_enable_r && pend) begin
          state_nxt = ivet_pkg::IVET_TAKE;
        end
      end
      ivet_pkg::IVET_TAKE: begin
        state_nxt = ivet_pkg::IVET_SERV;
      end
      ivet_pkg::IVET_SERV: begin
        if (reti_done) begin
          state_nxt = ivet_pkg::IVET_IDLE;
        end
      end
      default: state_nxt = ivet_pkg::IVET_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ivet_pkg::IVET_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // The take strobe carries the vector and one stack push.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_r <= '{take: 1'b0, push: 1'b0, addr: ivet_pkg::VEC_ADDR};
    end else if (ce) begin
      vec_r.take <= (state_nxt == ivet_pkg::IVET_TAKE);
      vec_r.push <= (state_nxt == ivet_pkg::IVET_TAKE);
      vec_r.addr <= ivet_pkg::VEC_ADDR;
    end
  end

  assign vec_out = vec_r;

  // One buffer level: a second save simply overwrites the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_r <= '0;
    end else if (ce && save_req) begin
      shadow_r.work <= ctx_in.work;
      shadow_r.psw <= ctx_in.psw & ~ivet_pkg::PSW_SKIP;
    end
  end

  // Restore hands back the saved pair; skipped bits stay live.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_r <= '0;
      ctx_valid_r <= 1'b0;
    end else if (ce) begin
      ctx_valid_r <= restore_req;
      if (restore_req) begin
        ctx_r.work <= shadow_r.work;
        ctx_r.psw <= (shadow_r.psw & ~ivet_pkg::PSW_SKIP) |
                     (ctx_in.psw & ivet_pkg::PSW_SKIP);
      end
    end
  end

  assign ctx_out = ctx_r;
  assign ctx_valid = ctx_valid_r;

  // Checks of the vectoring sequence, the flags and context save and restore.
  sequence take_seq;
    vec_r.take && vec_r.push && vec_r.addr == ivet_pkg::VEC_ADDR;
  endsequence

  sequence pend_seq;
    ce && state_r == ivet_pkg::IVET_IDLE && global_int_enable_r && pend;
  endsequence

  vec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    vec_r.take |-> take_seq)
    else $error("vector taken to a wrong address");

  vec_when_a: assert property (@(posedge pclk) disable iff (!presetn)
    pend_seq |=> take_seq)
    else $error("pending enabled request not vectored");

  push_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    vec_r.push && ce |=> !vec_r.push)
    else $error("stack pushed more than one level");

  gie_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    vec_r.take |-> $past(global_int_enable_r))
    else $error("vector taken with global enable low");

  no_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ivet_pkg::IVET_IDLE && !pend |=> !vec_r.take)
    else $error("unqualified request vectored");

  pin_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && set_evt[0] |=> flag[0])
    else $error("line 0 trigger lost");

  tmr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (timer0_ovf || timer1_ovf) |=> (flag[2] || !$past(timer0_ovf))
      && (flag[3] || !$past(timer1_ovf)))
    else $error("timer overflow lost");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag[2] && !(ce && wr_acc && idx == ivet_pkg::IDX_REQ) |=> flag[2])
    else $error("timer 0 flag cleared without a write");

  save_rest_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && restore_req |=> ctx_valid_r &&
      (ctx_r.psw & ivet_pkg::PSW_SKIP) ==
      ($past(ctx_in.psw) & ivet_pkg::PSW_SKIP))
    else $error("skipped status bits overwritten on restore");

  save_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && save_req ##1 ce && restore_req && !save_req |=>
      ctx_r.work == $past(ctx_in.work, 2))
    else $error("restored work register differs from saved");

  // Checks of the flags, the save buffer, the edge decode and of what software reads back.
  // A lost request here would never vector, so the flag set checks guard silent drops.
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && timer0_ovf && wr_acc && idx == ivet_pkg::IDX_REQ |=> flag[2])
    else $error("timer 0 set lost to a clearing write");

  tmr_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && timer0_ovf && !src_en[2] && !qual[2] |=> !qual[2])
    else $error("timer 0 request qualified while disabled");

  pin1_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && set_evt[1] |=> flag[1])
    else $error("line 1 trigger lost");

  save_buf_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && save_req |=> shadow_r.work == $past(ctx_in.work))
    else $error("save did not overwrite the buffer");

  req_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && idx == ivet_pkg::IDX_REQ |=>
      prdata_r[ivet_pkg::B_T0] == $past(flag[2]) &&
      prdata_r[ivet_pkg::B_EXT1] == $past(flag[1]))
    else $error("pending flag not readable");

  rsvd0_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    edge_r[ivet_pkg::EDGE0_LSB +: 2] == ivet_pkg::EDGE_RSVD |-> !ext_trig[0])
    else $error("line 0 reserved code triggered");

  rsvd1_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    edge_r[ivet_pkg::EDGE1_LSB +: 2] == ivet_pkg::EDGE_RSVD |-> !ext_trig[1])
    else $error("line 1 reserved code triggered");
endmodule // ivet_top
